// ---- sscs_pkg.sv ----
// Shared constants and types for the simultaneous sample conversion sequencer
package sscs_pkg;
	localparam int CHANNELS = 4;
	localparam int DATA_WIDTH = 14;
	localparam int SEL_WIDTH = 4;
	localparam int CLK_MHZ = 40;
	// Conversion time per channel in ns, and derived cycles (longest time rounds down)
	localparam int CONV_TIME_NS = 2400;
	localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
	// External timing: rising edges of the external timing input per conversion
	localparam int EXT_EDGES_PER_CONV = 16;
	// Host side spacing: acquisition 350 ns (least, round up), read guard 100 ns
	localparam int ACQ_TIME_NS = 350;
	localparam int ACQ_CYCLES = (ACQ_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam int GUARD_TIME_NS = 100;
	localparam int GUARD_CYCLES = (GUARD_TIME_NS * CLK_MHZ + 999) / 1000;
	// Four-channel sequence at most 100 kHz: period 10000 ns
	localparam int SEQ_PERIOD_NS = 10000;
	localparam int SEQ_CYCLES = (SEQ_PERIOD_NS * CLK_MHZ + 999) / 1000;
	localparam int START_LOW_CYCLES = 2;
	localparam int CNT_WIDTH = 16;
	// Host APB register offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_CHSEL = 8'h04;
	localparam logic [7:0] REG_STATUS = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	localparam logic [7:0] REG_RESULT0 = 8'h20;
	// Control bit positions
	localparam int CTRL_START = 0;
	localparam int CTRL_WRSEL = 1;
	localparam int CTRL_HWSW = 2;
	localparam int CTRL_CLKSRC = 3;
	localparam int CTRL_RDMODE = 4;
	localparam int CTRL_PINS = 8;
	// Interrupt bit positions
	localparam int IRQ_SEQ_DONE = 0;
	localparam int IRQ_RESULT = 1;
	localparam int IRQ_WIDTH = 2;
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_CONV = 2'b01,
		SEQ_EOC = 2'b10
	} sscs_seq_type;
	typedef enum logic [2:0] {
		HST_IDLE = 3'b000,
		HST_WRITE = 3'b001,
		HST_START = 3'b010,
		HST_WAIT = 3'b011,
		HST_READ = 3'b100,
		HST_ACQ = 3'b101
	} sscs_host_type;
endpackage : sscs_pkg

// ---- sscs_if.sv ----
// Parallel bus between converter control and host
`timescale 1ns/1ps
interface sscs_if;
	logic sample_start_n;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic [sscs_pkg::DATA_WIDTH-1:0] host_data;
	logic [sscs_pkg::DATA_WIDTH-1:0] dev_data;
	logic dev_data_oe_n;
	logic busy;
	logic eoc_n;
	modport device (input sample_start_n, cs_n, rd_n, wr_n, host_data, output dev_data, dev_data_oe_n, busy, eoc_n);
	modport host (output sample_start_n, cs_n, rd_n, wr_n, host_data, input dev_data, dev_data_oe_n, busy, eoc_n);
endinterface : sscs_if

// ---- sscs_timer.sv ----
// Conversion timer: internal cycle count or external timing edges
`timescale 1ns/1ps
module sscs_timer #(
	parameter int CONV_CYCLES = sscs_pkg::CONV_CYCLES,
	parameter int EXT_EDGES = sscs_pkg::EXT_EDGES_PER_CONV
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Control
	input wire logic run,
	input wire logic use_external,
	input wire logic external_timing_input,
	output logic done
);
	logic [sscs_pkg::CNT_WIDTH-1:0] cnt_reg;
	logic ext_s1_reg, ext_s2_reg, ext_prev_reg;
	wire ext_edge = ext_s2_reg & ~ext_prev_reg;
	wire tick = use_external ? ext_edge : 1'b1;
	wire [sscs_pkg::CNT_WIDTH-1:0] limit = use_external ? sscs_pkg::CNT_WIDTH'(EXT_EDGES - 1)
		: sscs_pkg::CNT_WIDTH'(CONV_CYCLES - 1);
	assign done = run & tick & (cnt_reg == limit);
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			ext_s1_reg <= 1'b0;
			ext_s2_reg <= 1'b0;
			ext_prev_reg <= 1'b0;
			cnt_reg <= '0;
		end else begin
			ext_s1_reg <= external_timing_input;
			ext_s2_reg <= ext_s1_reg;
			ext_prev_reg <= ext_s2_reg;
			if (!run || done)
				cnt_reg <= '0;
			else if (tick)
				cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule : sscs_timer

// ---- sscs_device.sv ----
// Converter control end: start capture, channel sequencing, strobes, result bus
// Functional notes
// - Start rising edge holds all, begins conversion
// - Convert only selected channels
// - Select low uses pins, high register
// - Write strobe captures low four lines
// - Channel set latched at start edge
// - Busy high for whole sequence
// - End-of-conversion strobe per channel
// - Internal timing unless source select high
// - Read between conversions or after busy
// - Results on 14-bit bus on read
// - Internal conversion takes 2.4 us
// - Host avoids reads during conversion; with CTRL_RDMODE set it reads while the next channel converts
// - Host waits acquisition time before start
// - Four-channel sequence at most 100 kHz
// - Register bit zero is channel one
// - End-of-conversion pulse is active low
// - Result bit 13 is the MSB
`timescale 1ns/1ps
module sscs_device #(
	parameter int CONV_CYCLES = sscs_pkg::CONV_CYCLES,
	parameter int EXT_EDGES = sscs_pkg::EXT_EDGES_PER_CONV
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Host bus
	sscs_if.device bus,
	// Straps and pins
	input wire logic [sscs_pkg::SEL_WIDTH-1:0] channel_pick_pins,
	input wire logic hw_sw_select,
	input wire logic clock_source_select,
	input wire logic external_timing_input,
	// Converter core results, one word per channel
	input wire logic [sscs_pkg::CHANNELS*sscs_pkg::DATA_WIDTH-1:0] sample_in,
	// Track/hold control
	output logic hold
);
	localparam int CH_W = $clog2(sscs_pkg::CHANNELS);
	sscs_pkg::sscs_seq_type state_reg;
	sscs_pkg::sscs_seq_type state_next;
	logic start_prev_reg;
	logic [sscs_pkg::SEL_WIDTH-1:0] chsel_reg;
	logic [sscs_pkg::SEL_WIDTH-1:0] active_reg;
	logic [sscs_pkg::CHANNELS*sscs_pkg::DATA_WIDTH-1:0] held_reg;
	logic [sscs_pkg::DATA_WIDTH-1:0] result_reg [sscs_pkg::CHANNELS];
	logic [CH_W-1:0] ch_reg;
	logic [CH_W-1:0] rd_ptr_reg;
	logic ext_mode_reg;
	logic busy_reg, eoc_n_reg, oe_n_reg, hold_reg;
	logic [sscs_pkg::DATA_WIDTH-1:0] dout_reg;
	logic conv_done;

	// First set bit at or above a position; ascending order
	function automatic logic [CH_W:0] next_ch(input logic [sscs_pkg::SEL_WIDTH-1:0] m, input int from);
		logic [CH_W:0] r;
		r = {1'b1, {CH_W{1'b0}}};
		for (int i = sscs_pkg::CHANNELS - 1; i >= 0; i--)
			if (i >= from && m[i])
				r = {1'b0, CH_W'(i)};
		return r;
	endfunction : next_ch

	// ==========================================
	// Decode
	wire start_rise = bus.sample_start_n & ~start_prev_reg;
	wire [sscs_pkg::SEL_WIDTH-1:0] pick = hw_sw_select ? chsel_reg : channel_pick_pins;
	wire [CH_W:0] first_ch = next_ch(pick, 0);
	wire [CH_W:0] later_ch = next_ch(active_reg, int'(ch_reg) + 1);
	wire write_strobe = ~bus.cs_n & ~bus.wr_n;
	wire read_on = ~bus.cs_n & ~bus.rd_n;
	wire [sscs_pkg::DATA_WIDTH-1:0] chan_word =
		held_reg[int'(ch_reg)*sscs_pkg::DATA_WIDTH +: sscs_pkg::DATA_WIDTH];
	// A start while busy is dropped; the running set stays latched
	wire launch = state_reg == sscs_pkg::SEQ_IDLE && start_rise && !first_ch[CH_W];
	wire timer_run = state_reg == sscs_pkg::SEQ_CONV;
	wire store = timer_run && conv_done;
	// Track/hold stays in hold from launch until the last channel is stored
	wire seq_end = state_reg == sscs_pkg::SEQ_EOC && later_ch[CH_W];

	// Timing source is sampled at launch so a mid-sequence change cannot split a conversion
	sscs_timer #(.CONV_CYCLES(CONV_CYCLES), .EXT_EDGES(EXT_EDGES)) i_sscs_timer (
		.core_clk(core_clk),
		.rstn(rstn),
		.run(timer_run),
		.use_external(ext_mode_reg),
		.external_timing_input(external_timing_input),
		.done(conv_done)
	);

	// ==========================================
	// Next state
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sscs_pkg::SEQ_IDLE: begin
				// A start with an empty selection is ignored: nothing to hold for
				if (launch)
					state_next = sscs_pkg::SEQ_CONV;
			end
			sscs_pkg::SEQ_CONV: begin
				if (conv_done)
					state_next = sscs_pkg::SEQ_EOC;
			end
			sscs_pkg::SEQ_EOC: begin
				// One spare cycle per channel lets the strobe end before timing restarts
				state_next = later_ch[CH_W] ? sscs_pkg::SEQ_IDLE : sscs_pkg::SEQ_CONV;
			end
			default: state_next = sscs_pkg::SEQ_IDLE;
		endcase
	end

	// ==========================================
	// Start edge and channel select register
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			start_prev_reg <= 1'b1;
			chsel_reg <= '0;
		end else begin
			start_prev_reg <= bus.sample_start_n;
			if (write_strobe)
				chsel_reg <= bus.host_data[sscs_pkg::SEL_WIDTH-1:0];
		end
	end

	// ==========================================
	// Sequence registers
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			state_reg <= sscs_pkg::SEQ_IDLE;
			active_reg <= '0;
			held_reg <= '0;
			ch_reg <= '0;
			ext_mode_reg <= 1'b0;
			busy_reg <= 1'b0;
			eoc_n_reg <= 1'b1;
			hold_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			eoc_n_reg <= ~store;
			if (launch) begin
				// All words freeze at one edge so the channels keep their relative phase
				held_reg <= sample_in;
				hold_reg <= 1'b1;
				active_reg <= pick;
				ch_reg <= first_ch[CH_W-1:0];
				ext_mode_reg <= clock_source_select;
				busy_reg <= 1'b1;
			end else if (seq_end) begin
				busy_reg <= 1'b0;
				hold_reg <= 1'b0;
			end else if (state_reg == sscs_pkg::SEQ_EOC)
				ch_reg <= later_ch[CH_W-1:0];
		end
	end

	// ==========================================
	// Result store, one word per channel
	generate
		for (genvar g = 0; g < sscs_pkg::CHANNELS; g++) begin : g_result
			wire load = store && ch_reg == CH_W'(g);
			always_ff @(posedge core_clk or negedge rstn) begin
				if (!rstn)
					result_reg[g] <= '0;
				else if (load)
					result_reg[g] <= chan_word;
			end
		end
	endgenerate

	// ==========================================
	// Read port: each read returns the next stored result in channel order
	// The pointer moves once per read strobe, so a long read still returns one word
	// After the last selected channel it wraps, letting a host read a set twice
	wire rd_fall = read_on & oe_n_reg;
	wire [CH_W:0] rd_next = next_ch(active_reg, int'(rd_ptr_reg) + 1);
	wire [CH_W:0] rd_first = next_ch(active_reg, 0);
	wire [CH_W-1:0] rd_ptr_next = rd_next[CH_W] ? rd_first[CH_W-1:0] : rd_next[CH_W-1:0];
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			oe_n_reg <= 1'b1;
			dout_reg <= '0;
		end else begin
			oe_n_reg <= ~read_on;
			if (rd_fall)
				dout_reg <= result_reg[rd_ptr_reg];
		end
	end
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn)
			rd_ptr_reg <= '0;
		else if (launch)
			rd_ptr_reg <= first_ch[CH_W-1:0];
		else if (rd_fall)
			rd_ptr_reg <= rd_ptr_next;
	end

	// ==========================================
	// Outputs
	assign bus.dev_data = dout_reg;
	assign bus.dev_data_oe_n = oe_n_reg;
	assign bus.busy = busy_reg;
	assign bus.eoc_n = eoc_n_reg;
	assign hold = hold_reg;
endmodule : sscs_device

// ---- sscs_host.sv ----
// Host end: APB-controlled start, channel register write and result readout
//
// Decided for this implementation: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module sscs_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	// Device bus
	sscs_if.host bus,
	// Straps to device
	output logic [sscs_pkg::SEL_WIDTH-1:0] channel_pick_pins,
	output logic hw_sw_select,
	output logic clock_source_select
);
	localparam int NCH = sscs_pkg::CHANNELS;
	sscs_pkg::sscs_host_type st_reg;
	logic [31:0] ctrl_reg, prdata_reg;
	logic [sscs_pkg::SEL_WIDTH-1:0] chsel_reg, left_reg;
	localparam int IRQ_W = sscs_pkg::IRQ_WIDTH;
	logic [IRQ_W-1:0] stat_reg, mask_reg;
	logic [sscs_pkg::DATA_WIDTH-1:0] res_reg [NCH];
	logic [1:0] idx_reg;
	logic [sscs_pkg::CNT_WIDTH-1:0] wait_reg, period_reg;
	logic start_n_reg, cs_n_reg, rd_n_reg, wr_n_reg, busy_prev_reg, eoc_prev_reg, irq_reg, pready_reg;
	logic [sscs_pkg::DATA_WIDTH-1:0] hd_reg;
	logic [IRQ_W-1:0] ev;

	wire acc = psel & penable & ~pready_reg;
	// Writes land at the edge where pready is seen high, the last edge of the request
	wire wr = psel & penable & pready_reg & pwrite;
	wire known = paddr inside {sscs_pkg::REG_CTRL, sscs_pkg::REG_CHSEL, sscs_pkg::REG_STATUS,
		sscs_pkg::REG_IRQ_STAT, sscs_pkg::REG_IRQ_MASK} ||
		(paddr[7:4] == sscs_pkg::REG_RESULT0[7:4] && {1'b0, paddr[3:2]} < 3'(NCH));
	wire go_start = wr && paddr == sscs_pkg::REG_CTRL && pwdata[sscs_pkg::CTRL_START];
	wire go_write = wr && paddr == sscs_pkg::REG_CTRL && pwdata[sscs_pkg::CTRL_WRSEL];
	wire between = ctrl_reg[sscs_pkg::CTRL_RDMODE];
	wire eoc_rise = bus.eoc_n & ~eoc_prev_reg;
	wire busy_fall = ~bus.busy & busy_prev_reg;
	wire [31:0] rd_mux =
		paddr == sscs_pkg::REG_CTRL ? ctrl_reg :
		paddr == sscs_pkg::REG_CHSEL ? 32'(chsel_reg) :
		paddr == sscs_pkg::REG_STATUS ? {29'h0, bus.busy, st_reg != sscs_pkg::HST_IDLE, bus.eoc_n} :
		paddr == sscs_pkg::REG_IRQ_STAT ? 32'(stat_reg) :
		paddr == sscs_pkg::REG_IRQ_MASK ? 32'(mask_reg) :
		paddr[7:4] == sscs_pkg::REG_RESULT0[7:4] ? 32'(res_reg[paddr[3:2]]) : 32'h0000_0000;
	// Next channel to read: lowest bit still pending
	wire [1:0] low_left = left_reg[0] ? 2'd0 : left_reg[1] ? 2'd1 : left_reg[2] ? 2'd2 : 2'd3;
	assign ev[sscs_pkg::IRQ_SEQ_DONE] = busy_fall;
	assign ev[sscs_pkg::IRQ_RESULT] = st_reg == sscs_pkg::HST_READ && wait_reg == '0;

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			pready_reg <= 1'b0;
			prdata_reg <= 32'h0000_0000;
			ctrl_reg <= 32'h0000_0000;
			chsel_reg <= '0;
			stat_reg <= '0;
			mask_reg <= '0;
			irq_reg <= 1'b0;
		end else begin
			pready_reg <= acc;
			if (acc)
				prdata_reg <= known ? rd_mux : 32'h0000_0000;
			if (wr && paddr == sscs_pkg::REG_CTRL)
				ctrl_reg <= pwdata & ~(32'h1 << sscs_pkg::CTRL_START) & ~(32'h1 << sscs_pkg::CTRL_WRSEL);
			if (wr && paddr == sscs_pkg::REG_CHSEL)
				chsel_reg <= pwdata[sscs_pkg::SEL_WIDTH-1:0];
			if (wr && paddr == sscs_pkg::REG_IRQ_MASK)
				mask_reg <= pwdata[IRQ_W-1:0];
			// Set wins over write-one clear
			stat_reg <= (stat_reg & ~((wr && paddr == sscs_pkg::REG_IRQ_STAT) ? pwdata[IRQ_W-1:0] : '0)) | ev;
			irq_reg <= |(stat_reg & mask_reg);
		end
	end

	// ==========================================
	// Device bus sequencer
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st_reg <= sscs_pkg::HST_IDLE;
			start_n_reg <= 1'b1;
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			hd_reg <= '0;
			wait_reg <= '0;
			period_reg <= '0;
			left_reg <= '0;
			idx_reg <= '0;
			busy_prev_reg <= 1'b0;
			eoc_prev_reg <= 1'b1;
			for (int i = 0; i < NCH; i++)
				res_reg[i] <= '0;
		end else begin
			busy_prev_reg <= bus.busy;
			eoc_prev_reg <= bus.eoc_n;
			if (period_reg != '0)
				period_reg <= period_reg - 1'b1;
			if (wait_reg != '0)
				wait_reg <= wait_reg - 1'b1;
			case (st_reg)
				sscs_pkg::HST_IDLE: begin
					if (go_write) begin
						cs_n_reg <= 1'b0;
						wr_n_reg <= 1'b0;
						hd_reg <= sscs_pkg::DATA_WIDTH'(chsel_reg);
						wait_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::GUARD_CYCLES);
						st_reg <= sscs_pkg::HST_WRITE;
					end else if (go_start && period_reg == '0 && wait_reg == '0) begin
						start_n_reg <= 1'b0;
						wait_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::START_LOW_CYCLES);
						period_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::SEQ_CYCLES);
						left_reg <= hw_sw_select ? chsel_reg : channel_pick_pins;
						st_reg <= sscs_pkg::HST_START;
					end
				end
				sscs_pkg::HST_WRITE: if (wait_reg == '0) begin
					cs_n_reg <= 1'b1;
					wr_n_reg <= 1'b1;
					st_reg <= sscs_pkg::HST_IDLE;
				end
				sscs_pkg::HST_START: if (wait_reg == '0) begin
					// Busy shows two edges after the rising start; watch it only then
					if (!start_n_reg) begin
						start_n_reg <= 1'b1;
						wait_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::START_LOW_CYCLES);
					end else
						st_reg <= sscs_pkg::HST_WAIT;
				end
				sscs_pkg::HST_WAIT: begin
					// Reads only after an end strobe or once busy is low
					if (left_reg == '0) begin
						if (!bus.busy) begin
							wait_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::ACQ_CYCLES);
							st_reg <= sscs_pkg::HST_ACQ;
						end
					end else if ((between && eoc_rise) || !bus.busy) begin
						cs_n_reg <= 1'b0;
						rd_n_reg <= 1'b0;
						idx_reg <= low_left;
						wait_reg <= sscs_pkg::CNT_WIDTH'(sscs_pkg::GUARD_CYCLES);
						st_reg <= sscs_pkg::HST_READ;
					end
				end
				sscs_pkg::HST_READ: if (wait_reg == '0) begin
					res_reg[idx_reg] <= bus.dev_data;
					left_reg[idx_reg] <= 1'b0;
					cs_n_reg <= 1'b1;
					rd_n_reg <= 1'b1;
					st_reg <= sscs_pkg::HST_WAIT;
				end
				sscs_pkg::HST_ACQ: if (wait_reg == '0)
					st_reg <= sscs_pkg::HST_IDLE;
				default: st_reg <= sscs_pkg::HST_IDLE;
			endcase
		end
	end

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = 1'b0;
	assign irq = irq_reg;
	assign bus.sample_start_n = start_n_reg;
	assign bus.cs_n = cs_n_reg;
	assign bus.rd_n = rd_n_reg;
	assign bus.wr_n = wr_n_reg;
	assign bus.host_data = hd_reg;
	assign channel_pick_pins = ctrl_reg[sscs_pkg::CTRL_PINS +: sscs_pkg::SEL_WIDTH];
	assign hw_sw_select = ctrl_reg[sscs_pkg::CTRL_HWSW];
	assign clock_source_select = ctrl_reg[sscs_pkg::CTRL_CLKSRC];
endmodule : sscs_host

// ---- sscs_properties.sv ----
// Bus-level checks for the converter control and host pair
`timescale 1ns/1ps
module sscs_properties #(
	parameter int CONV_CYCLES = 8
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// Bus signals
	input wire logic sample_start_n,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic dev_data_oe_n,
	input wire logic busy,
	input wire logic eoc_n,
	// Track/hold
	input wire logic hold
);
	// ==========================================
	// Helper: busy cycles since last strobe
	logic [15:0] gap_reg;
	logic [15:0] gap_next;
	assign gap_next = (!busy || !eoc_n) ? 16'h0000 : gap_reg + 16'h0001;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) gap_reg <= 16'h0000;
		else gap_reg <= gap_next;
	end
	// ==========================================
	// Properties
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	sequence start_seen;
		$rose(sample_start_n) && !busy;
	endsequence
	sequence seq_begin;
		busy && hold;
	endsequence
	property start_launch;
		start_seen |-> ##[1:2] seq_begin;
	endproperty
	start_busy_a: assert property (start_launch) else $error("busy or hold late after start");
	busy_end_a: assert property ($fell(busy) |-> !$past(eoc_n)) else $error("busy fell without last strobe");
	track_return_a: assert property ($fell(busy) |-> !hold) else $error("hold kept after sequence");
	eoc_inside_a: assert property (!eoc_n |-> busy && hold) else $error("strobe outside sequence");
	eoc_pulse_a: assert property ($fell(eoc_n) |=> eoc_n) else $error("strobe longer than one cycle");
	// Lower bound only: external timing may stretch a conversion
	conv_time_a: assert property (!eoc_n |-> gap_reg >= 16'(CONV_CYCLES - 2)) else $error("conversion too short");
	oe_cause_a: assert property (!dev_data_oe_n |-> !$past(cs_n) && !$past(rd_n)) else $error("bus driven unasked");
	oe_drive_a: assert property (!cs_n && !rd_n |=> !dev_data_oe_n) else $error("read not answered");
	acq_wait_a: assert property ($fell(busy) |=> sample_start_n [*8]) else $error("start inside acquisition");
	start_cov_c: cover property (start_seen);
endmodule : sscs_properties

// ---- test_simultaneous_sample_conversion_sequencer.sv ----
// Self-checking bench for the host and converter control pair
`timescale 1ns/1ps
module test_simultaneous_sample_conversion_sequencer;
	// ==========================================
	// Signals
	logic core_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic irq;
	logic ext_tick = 1'b0;
	logic [1:0] ext_cnt = 2'h0;
	logic [3:0] pins;
	logic hw_sw;
	logic clk_src;
	logic hold;
	logic [55:0] samples = {14'h1004, 14'h3fff, 14'h0b3c, 14'h2a51};
	logic [31:0] rd;
	logic mask_on = 1'b0;
	int eoc_cnt = 0;
	int tnum = 0;
	int miscompares = 0;
	int total_checks = 0;
	// ==========================================
	// Clocks and instances
	always #12.5 core_clk = ~core_clk;
	// Slow external timing, one toggle every four cycles
	always @(posedge core_clk) begin
		ext_cnt <= ext_cnt + 2'h1;
		if (ext_cnt == 2'h3) ext_tick <= ~ext_tick;
		if (rstn && bus_if.eoc_n === 1'b0) eoc_cnt++;
	end
	sscs_if bus_if();
	sscs_device #(.CONV_CYCLES(8)) i_sscs_device (.core_clk, .rstn, .bus(bus_if.device),
		.channel_pick_pins(pins), .hw_sw_select(hw_sw), .clock_source_select(clk_src),
		.external_timing_input(ext_tick), .sample_in(samples), .hold);
	sscs_host i_sscs_host (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .irq, .bus(bus_if.host), .channel_pick_pins(pins), .hw_sw_select(hw_sw),
		.clock_source_select(clk_src));
	sscs_properties #(.CONV_CYCLES(8)) i_sscs_properties (.core_clk, .rstn,
		.sample_start_n(bus_if.sample_start_n), .cs_n(bus_if.cs_n), .rd_n(bus_if.rd_n),
		.dev_data_oe_n(bus_if.dev_data_oe_n), .busy(bus_if.busy), .eoc_n(bus_if.eoc_n), .hold);
	// ==========================================
	// Tasks
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : conclude
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
		end
	endtask : chk
	// Idle edge after each transfer keeps strobes from being set twice at one edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) chk(32'h0, 32'h1, "no pready");
		@(posedge core_clk);
	endtask : apb
	task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] want);
		int n;
		n = 0;
		do begin
			apb(1'b0, a, 32'h0);
			n++;
		end while ((rd & m) !== want && n < 500);
		if (n >= 500) chk(rd & m, want, "poll timeout");
	endtask : poll
	task automatic run_seq(input logic [31:0] ctrl, input logic [3:0] sel, input logic [31:0] late);
		repeat (420) @(posedge core_clk);
		samples <= {samples[41:0], samples[55:42]};
		apb(1'b1, sscs_pkg::REG_CTRL, ctrl & ~32'h1);
		eoc_cnt = 0;
		apb(1'b1, sscs_pkg::REG_CTRL, ctrl);
		if (late != 32'h0) apb(1'b1, sscs_pkg::REG_CTRL, late);
		poll(sscs_pkg::REG_IRQ_STAT, 32'h1, 32'h1);
		poll(sscs_pkg::REG_STATUS, 32'h6, 32'h0);
		chk(32'(eoc_cnt), 32'($countones(sel)), "strobe count");
		for (int c = 0; c < 4; c++) begin
			if (sel[c]) begin
				apb(1'b0, sscs_pkg::REG_RESULT0 + 8'(4 * c), 32'h0);
				chk(rd, {18'h0, samples[14 * c +: 14]}, "result word");
			end
		end
		chk({31'h0, irq}, {31'h0, mask_on}, "irq level");
		apb(1'b1, sscs_pkg::REG_IRQ_STAT, 32'h3);
		// The level follows the cleared status one edge later
		@(posedge core_clk);
		chk({31'h0, irq}, 32'h0, "irq after clear");
		tnum++;
		$display("test %0d done", tnum);
	endtask : run_seq
	// ==========================================
	// Tests
	initial begin
		repeat (3) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		chk({29'h0, bus_if.busy, bus_if.eoc_n, bus_if.dev_data_oe_n}, 32'h3, "reset levels");
		apb(1'b0, 8'h40, 32'h0);
		chk(rd, 32'h0, "unmapped read");
		apb(1'b1, sscs_pkg::REG_IRQ_MASK, 32'h1);
		mask_on = 1'b1;
		run_seq(32'h0501, 4'b0101, 32'h0);
		// Pins move while busy; the running set must stay
		run_seq(32'h0301, 4'b0011, 32'h0700);
		apb(1'b1, sscs_pkg::REG_IRQ_MASK, 32'h0);
		mask_on = 1'b0;
		apb(1'b1, sscs_pkg::REG_CHSEL, 32'ha);
		apb(1'b1, sscs_pkg::REG_CTRL, 32'h0106);
		repeat (20) @(posedge core_clk);
		run_seq(32'h0115, 4'b1010, 32'h0);
		apb(1'b1, sscs_pkg::REG_CHSEL, 32'hf);
		apb(1'b1, sscs_pkg::REG_CTRL, 32'h0006);
		repeat (20) @(posedge core_clk);
		run_seq(32'h000d, 4'b1111, 32'h0);
		conclude();
	end
	initial begin
		#(25ns * 30000);
		miscompares++;
		$display("ERROR %0t watchdog expired", $time);
		conclude();
	end
endmodule : test_simultaneous_sample_conversion_sequencer
